// *** design/modbus_rtu_master_request.sv ***
// What this block does
// - slave station address accepted from 0 to 247, else request refused
// - read function codes 01, 02, 03, 04 and 07 supported
// - write function codes 05, 06, 15 and 16 supported
// - element count used only by codes 15 and 16 among writes
// - exception reply stored as six bytes in three words at buffer address
// - word one: function code with top bit high, then slave address low
// - word two: first crc byte high, exception code low
// - word three: zero high, other crc byte low
// - busy flag high for the whole exchange, low when it ends
// - error flag set on any error, cleared when a new request executes
// - only serial port two accepted for requests
// - each request picks 484 or 584/984 numbering, which sets address ranges
// - 484 ranges: coils 1-999, inputs 1001-1999, iregs 3001-3999, hregs 4001-4999
// - 584/984: coils 1-65535, register and input five or six digit ranges
// - count 1-2000 for bits, 1-125 for registers, or from word memory
// - read exception status uses no slave start address
// - read reply items written to word memory from master start address
// - write request sends consecutive memory items from master start address
// - master start address may be any word memory address
//
// The implementer's own choices: the address map and the APB register port.
`default_nettype none
`include "modbus_params.svh"

module modbus_rtu_master_request #(
	parameter int MEM_AW = 10,
	parameter int CLKS_PER_BIT = `CLK_HZ / `BAUD_RATE,
	parameter int TIMEOUT_CYCLES = `CLK_HZ / 1000 * `RESP_TIMEOUT_MS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [12:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd,
	output logic txd,
	output logic tx_drive_en,
	output logic port_busy_flag,
	output logic port_comm_error_flag
);

	localparam int MEM_WORDS = 2 ** MEM_AW;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] x;
		x = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			x = x[0] ? ((x >> 1) ^ `CRC_POLY) : (x >> 1);
		end
		return x;
	endfunction

	function automatic modbus_pkg::start_map_t map_start(input logic [7:0] fc,
			input logic m984, input logic [19:0] sa);
		logic [1:0] kind;
		logic [19:0] lo;
		logic [19:0] span;
		logic [19:0] off;
		modbus_pkg::start_map_t r;
		kind = (fc == `FC_RD_INPUTS) ? 2'h1 : (fc == `FC_RD_IREGS) ? 2'h2 :
			(fc == `FC_RD_HREGS || fc == `FC_WR_REG || fc == `FC_WR_REGS) ? 2'h3 : 2'h0;
		if (!m984) begin
			unique case (kind)
				2'h0: lo = `B484_COIL;
				2'h1: lo = `B484_INP;
				2'h2: lo = `B484_IREG;
				2'h3: lo = `B484_HREG;
			endcase
			span = `SPAN_484;
		end else if (kind == 2'h0) begin
			lo = `B484_COIL;
			span = `SPAN_6D;
		end else begin
			unique case (kind)
				2'h1: lo = (sa >= `B6_INP) ? `B6_INP : `B5_INP;
				2'h2: lo = (sa >= `B6_IREG) ? `B6_IREG : `B5_IREG;
				default: lo = (sa >= `B6_HREG) ? `B6_HREG : `B5_HREG;
			endcase
			span = (sa >= `B6_INP) ? `SPAN_6D : `SPAN_5D;
		end
		off = sa - lo;
		r.ok = (fc == `FC_RD_EXC) || (sa >= lo && off <= span);
		r.offset = (fc == `FC_RD_EXC) ? 16'h0000 : off[15:0];
		return r;
	endfunction

	logic [15:0] mem [MEM_WORDS];
	logic [31:0] cfg_reg;
	logic [19:0] sstart_reg;
	logic [15:0] mstart_reg;
	logic [15:0] count_reg;
	logic [15:0] excbuf_reg;
	logic err_reg;
	modbus_pkg::cause_t cause_reg;
	modbus_pkg::state_t state;
	modbus_pkg::req_t req;
	logic [8:0] tx_idx;
	logic [15:0] crc_reg;
	logic [5:0] gap_cnt;
	logic [8:0] rx_pos;
	logic [8:0] rx_len;
	logic [31:0] tmo_cnt;
	logic exc_seen;
	logic [1:0] exw_cnt;
	logic [7:0] exc_fc;
	logic [7:0] exc_code;
	logic [7:0] exc_crc1;
	logic [7:0] exc_crc2;
	logic [15:0] baud_cnt;
	logic [9:0] tx_sh;
	logic [3:0] tx_cnt;
	logic rx_s1;
	logic rx_s2;
	logic rx_s3;
	logic rx_lvl;
	logic rx_on;
	logic [3:0] rx_bit;
	logic [15:0] rx_cnt;
	logic [7:0] rx_data;
	logic rx_valid;
	logic rx_ferr;

	// apb decode
	wire logic apb_acc = psel && penable;
	wire logic apb_wr = apb_acc && pwrite;
	wire logic in_mem = paddr[`MEM_BASE_BIT] && ({1'b0, paddr[11:2]} < 11'(MEM_WORDS));
	wire logic [MEM_AW-1:0] apb_idx = paddr[MEM_AW+1:2];
	wire logic hit_ctrl = paddr == `CTRL_OFS;
	wire logic hit_cfg = paddr == `CFG_OFS;
	wire logic hit_ss = paddr == `SSTART_OFS;
	wire logic hit_ms = paddr == `MSTART_OFS;
	wire logic hit_cnt = paddr == `COUNT_OFS;
	wire logic hit_exb = paddr == `EXCBUF_OFS;
	wire logic hit_st = paddr == `STATUS_OFS;
	wire logic mapped = in_mem || hit_ctrl || hit_cfg || hit_ss || hit_ms || hit_cnt
		|| hit_exb || hit_st;
	wire logic busy = state != modbus_pkg::ST_IDLE;
	wire logic go = apb_wr && hit_ctrl && pwdata[`CTRL_GO_BIT];
	wire logic mem_we;

	// the engine owns the memory port; a clashing bus write waits while mem_we is high, up to three cycles of exception words
	assign pready = !(apb_wr && in_mem && mem_we);
	assign pslverr = apb_acc && !mapped;

	wire logic [31:0] status_word = {20'h00000, cause_reg, 5'h00, exc_seen, err_reg, busy};
	wire logic [31:0] rd_mux = in_mem ? {16'h0000, mem[apb_idx]} :
		hit_cfg ? cfg_reg :
		hit_ss ? {12'h000, sstart_reg} :
		hit_ms ? {16'h0000, mstart_reg} :
		hit_cnt ? {16'h0000, count_reg} :
		hit_exb ? {16'h0000, excbuf_reg} :
		hit_st ? status_word : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= `CFG_RESET;
			sstart_reg <= `SSTART_RESET;
			mstart_reg <= `WORD_RESET;
			count_reg <= `WORD_RESET;
			excbuf_reg <= `WORD_RESET;
		end else if (apb_wr) begin
			if (hit_cfg) cfg_reg <= pwdata;
			if (hit_ss) sstart_reg <= pwdata[19:0];
			if (hit_ms) mstart_reg <= pwdata[15:0];
			if (hit_cnt) count_reg <= pwdata[15:0];
			if (hit_exb) excbuf_reg <= pwdata[15:0];
		end
	end

	// request check against the configuration registers
	wire logic [7:0] cfg_slave = cfg_reg[`CFG_SLAVE_LSB +: 8];
	wire logic [7:0] cfg_fc = cfg_reg[`CFG_FC_LSB +: 8];
	wire logic [2:0] cfg_port = cfg_reg[`CFG_PORT_LSB +: 3];
	wire logic cfg_984 = cfg_reg[`CFG_MODE_BIT];
	wire logic [15:0] count_eff = cfg_reg[`CFG_CNTMEM_BIT] ? mem[count_reg[MEM_AW-1:0]]
		: count_reg;
	wire logic c_rd = cfg_fc == `FC_RD_COILS || cfg_fc == `FC_RD_INPUTS
		|| cfg_fc == `FC_RD_HREGS || cfg_fc == `FC_RD_IREGS || cfg_fc == `FC_RD_EXC;
	wire logic c_wr = cfg_fc == `FC_WR_COIL || cfg_fc == `FC_WR_REG
		|| cfg_fc == `FC_WR_COILS || cfg_fc == `FC_WR_REGS;
	wire logic c_bits = cfg_fc == `FC_RD_COILS || cfg_fc == `FC_RD_INPUTS
		|| cfg_fc == `FC_WR_COILS;
	wire logic c_regs = cfg_fc == `FC_RD_HREGS || cfg_fc == `FC_RD_IREGS
		|| cfg_fc == `FC_WR_REGS;
	wire modbus_pkg::start_map_t smap = map_start(cfg_fc, cfg_984, sstart_reg);
	// single writes and code 07 never look at the count
	wire logic cnt_ok = c_bits ? (count_eff != 16'h0000 && count_eff <= `MAX_BITS) :
		c_regs ? (count_eff != 16'h0000 && count_eff <= `MAX_REGS) : 1'b1;
	wire logic req_ok = cfg_port == `SERIAL_PORT_TWO
		&& cfg_slave <= `MAX_SLAVE
		&& (c_rd || c_wr) && smap.ok && cnt_ok;

	// latched request decode
	wire logic r_fc5 = req.fc == `FC_WR_COIL;
	wire logic r_fc6 = req.fc == `FC_WR_REG;
	wire logic r_fc7 = req.fc == `FC_RD_EXC;
	wire logic r_fc15 = req.fc == `FC_WR_COILS;
	wire logic r_fc16 = req.fc == `FC_WR_REGS;
	wire logic r_rdblk = req.fc >= `FC_RD_COILS && req.fc <= `FC_RD_IREGS;
	wire logic r_regs = req.fc == `FC_RD_HREGS || req.fc == `FC_RD_IREGS || r_fc16;
	wire logic [7:0] byte_cnt = r_regs ? 8'(req.count << 1)
		: 8'((req.count + 16'h0007) >> 3);
	wire logic [7:0] data_len = (r_fc15 || r_fc16) ? byte_cnt : 8'h00;
	wire logic [8:0] hdr_len = r_fc7 ? 9'h002 : (r_fc15 || r_fc16) ? 9'h007 : 9'h006;
	wire logic [8:0] tx_len = hdr_len + {1'b0, data_len};
	wire logic [8:0] tx_last = tx_len + 9'h001;

	// one byte pointer serves both directions; coils pack low byte first
	wire logic in_rx = state == modbus_pkg::ST_RX;
	wire logic [8:0] tx_p = (tx_idx < 9'h007) ? 9'h000 : tx_idx - 9'h007;
	wire logic [8:0] rx_p = r_fc7 ? rx_pos - 9'h002 : rx_pos - 9'h003;
	wire logic [8:0] dpos = in_rx ? rx_p : tx_p;
	wire logic sel_hi = dpos[0] ^ r_regs;
	wire logic [15:0] dword_addr = req.mstart + {8'h00, dpos[8:1]};
	wire logic [15:0] dword = mem[dword_addr[MEM_AW-1:0]];
	wire logic [7:0] data_byte = sel_hi ? dword[15:8] : dword[7:0];
	wire logic [7:0] f4 = r_fc5 ? {8{dword[0]}} : r_fc6 ? dword[15:8] : req.count[15:8];
	wire logic [7:0] f5 = r_fc5 ? 8'h00 : r_fc6 ? dword[7:0] : req.count[7:0];
	wire logic [7:0] tx_byte = (tx_idx == tx_len) ? crc_reg[7:0] :
		(tx_idx == tx_last) ? crc_reg[15:8] :
		(tx_idx == 9'h000) ? req.slave :
		(tx_idx == 9'h001) ? req.fc :
		(tx_idx == 9'h002) ? req.offset[15:8] :
		(tx_idx == 9'h003) ? req.offset[7:0] :
		(tx_idx == 9'h004) ? f4 :
		(tx_idx == 9'h005) ? f5 :
		(tx_idx == 9'h006) ? data_len : data_byte;

	// baud enable and transmitter
	wire logic baud_tick = baud_cnt == 16'(CLKS_PER_BIT - 1);
	wire logic tx_busy = tx_cnt != 4'h0;
	wire logic tx_load = state == modbus_pkg::ST_TX && !tx_busy && tx_idx <= tx_last;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_cnt <= 16'h0000;
		end else begin
			baud_cnt <= baud_tick ? 16'h0000 : baud_cnt + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txd <= 1'b1;
			tx_sh <= 10'h3FF;
			tx_cnt <= 4'h0;
		end else if (tx_load) begin
			tx_sh <= {1'b1, tx_byte, 1'b0};
			tx_cnt <= `UART_FRAME_TICKS;
		end else if (baud_tick && tx_busy) begin
			// last tick only closes the stop bit
			if (tx_cnt > 4'h1) begin
				txd <= tx_sh[0];
				tx_sh <= {1'b1, tx_sh[9:1]};
			end
			tx_cnt <= tx_cnt - 4'h1;
		end
	end

	// receiver: line filtered until two late stages agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_s3 <= 1'b1;
			rx_lvl <= 1'b1;
		end else begin
			rx_s1 <= rxd;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
			if (rx_s2 == rx_s3) rx_lvl <= rx_s3;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_on <= 1'b0;
			rx_bit <= 4'h0;
			rx_cnt <= 16'h0000;
			rx_data <= 8'h00;
			rx_valid <= 1'b0;
			rx_ferr <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			rx_ferr <= 1'b0;
			if (!rx_on) begin
				if (!rx_lvl) begin
					rx_on <= 1'b1;
					rx_bit <= 4'h0;
					rx_cnt <= 16'(CLKS_PER_BIT / 2);
				end
			end else if (rx_cnt != 16'h0000) begin
				rx_cnt <= rx_cnt - 16'h0001;
			end else begin
				rx_cnt <= 16'(CLKS_PER_BIT - 1);
				rx_bit <= rx_bit + 4'h1;
				if (rx_bit == 4'h0) begin
					if (rx_lvl) rx_on <= 1'b0;
				end else if (rx_bit < 4'h9) begin
					rx_data <= {rx_lvl, rx_data[7:1]};
				end else begin
					rx_on <= 1'b0;
					rx_valid <= rx_lvl;
					rx_ferr <= !rx_lvl;
				end
			end
		end
	end

	// reply checks
	wire logic rx_take = in_rx && rx_valid;
	wire logic [15:0] crc_rx = crc_step(crc_reg, rx_data);
	wire logic is_exc_fc = rx_data == (req.fc | `FC_EXC_BIT);
	wire logic bad_addr = rx_pos == 9'h000 && rx_data != req.slave;
	wire logic bad_fc = rx_pos == 9'h001 && rx_data != req.fc && !is_exc_fc;
	wire logic bad_bc = rx_pos == 9'h002 && r_rdblk && !exc_seen && rx_data != byte_cnt;
	wire logic hdr_err = rx_take && (bad_addr || bad_fc || bad_bc);
	wire logic last_rx = rx_take && 9'(rx_pos + 9'h001) == rx_len;
	wire logic crc_bad = last_rx && crc_rx != 16'h0000;
	wire logic tmo_hit = in_rx && tmo_cnt == 32'(TIMEOUT_CYCLES - 1);
	wire logic rx_fail = (in_rx && rx_ferr) || tmo_hit || hdr_err || crc_bad;
	wire logic rx_data_ph = !exc_seen && (r_fc7 ? rx_pos == 9'h002 :
		r_rdblk && rx_pos >= 9'h003 && rx_pos < 9'h003 + {1'b0, byte_cnt});
	wire logic rx_we = rx_take && rx_data_ph;

	// exception words, high byte then low byte
	wire logic exw = state == modbus_pkg::ST_EXCW;
	wire logic [15:0] exw_word = (exw_cnt == 2'h0) ? {exc_fc, req.slave} :
		(exw_cnt == 2'h1) ? {exc_crc1, exc_code} :
		{8'h00, exc_crc2};
	wire logic [15:0] exw_addr = req.excbuf + {14'h0000, exw_cnt};
	wire logic [15:0] fsm_wa = exw ? exw_addr : dword_addr;
	wire logic [1:0] fsm_be = exw ? 2'h3 : sel_hi ? 2'h2 : 2'h1;
	wire logic [15:0] fsm_wd = exw ? exw_word : {rx_data, rx_data};
	assign mem_we = rx_we || exw;

	always_ff @(posedge pclk) begin
		if (mem_we) begin
			if (fsm_be[1]) mem[fsm_wa[MEM_AW-1:0]][15:8] <= fsm_wd[15:8];
			if (fsm_be[0]) mem[fsm_wa[MEM_AW-1:0]][7:0] <= fsm_wd[7:0];
		end else if (apb_wr && in_mem) begin
			mem[apb_idx] <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= modbus_pkg::ST_IDLE;
			req <= '0;
			tx_idx <= 9'h000;
			crc_reg <= `CRC_INIT;
			gap_cnt <= 6'h00;
			rx_pos <= 9'h000;
			rx_len <= 9'h1FF;
			tmo_cnt <= 32'h0000_0000;
			exc_seen <= 1'b0;
			exw_cnt <= 2'h0;
		end else begin
			unique case (state)
				modbus_pkg::ST_IDLE: begin
					if (go && req_ok) begin
						state <= modbus_pkg::ST_GAP;
						req <= '{cfg_slave, cfg_fc, smap.offset, count_eff, mstart_reg,
							excbuf_reg};
						gap_cnt <= 6'h00;
						tx_idx <= 9'h000;
						crc_reg <= `CRC_INIT;
						exc_seen <= 1'b0;
					end
				end
				modbus_pkg::ST_GAP: begin
					// line silence ahead of the frame marks its start
					if (baud_tick) begin
						gap_cnt <= gap_cnt + 6'h01;
						if (gap_cnt == 6'(`GAP_BITS - 1)) state <= modbus_pkg::ST_TX;
					end
				end
				modbus_pkg::ST_TX: begin
					if (tx_load) begin
						tx_idx <= tx_idx + 9'h001;
						if (tx_idx < tx_len) crc_reg <= crc_step(crc_reg, tx_byte);
					end else if (!tx_busy) begin
						// broadcast gets no reply, so the exchange ends here
						state <= (req.slave == 8'h00) ? modbus_pkg::ST_IDLE : modbus_pkg::ST_RX;
						crc_reg <= `CRC_INIT;
						rx_pos <= 9'h000;
						rx_len <= 9'h1FF;
						tmo_cnt <= 32'h0000_0000;
					end
				end
				modbus_pkg::ST_RX: begin
					if (rx_fail) begin
						state <= modbus_pkg::ST_IDLE;
					end else if (last_rx) begin
						state <= exc_seen ? modbus_pkg::ST_EXCW : modbus_pkg::ST_IDLE;
						exw_cnt <= 2'h0;
					end else if (rx_take) begin
						rx_pos <= rx_pos + 9'h001;
						crc_reg <= crc_rx;
						tmo_cnt <= 32'h0000_0000;
						if (rx_pos == 9'h001) begin
							exc_seen <= is_exc_fc;
							rx_len <= (is_exc_fc || r_fc7) ? 9'h005 : r_rdblk ? 9'h1FF : 9'h008;
						end
						if (rx_pos == 9'h002 && r_rdblk && !exc_seen) begin
							rx_len <= 9'h005 + {1'b0, rx_data};
						end
					end else begin
						tmo_cnt <= tmo_cnt + 32'h0000_0001;
					end
				end
				modbus_pkg::ST_EXCW: begin
					exw_cnt <= exw_cnt + 2'h1;
					if (exw_cnt == 2'h2) state <= modbus_pkg::ST_IDLE;
				end
				default: state <= modbus_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exc_fc <= 8'h00;
			exc_code <= 8'h00;
			exc_crc1 <= 8'h00;
			exc_crc2 <= 8'h00;
		end else if (rx_take) begin
			if (rx_pos == 9'h001) exc_fc <= rx_data;
			if (rx_pos == 9'h002) exc_code <= rx_data;
			if (rx_pos == 9'h003) exc_crc1 <= rx_data;
			if (rx_pos == 9'h004) exc_crc2 <= rx_data;
		end
	end

	// a failing request sets the flag; on a refused go the set wins over the clear from that same go
	wire logic err_set = (!busy && go && !req_ok) || rx_fail || (last_rx && exc_seen);
	wire logic err_clr = !busy && go;
	wire modbus_pkg::cause_t cause_next = (!busy && go && !req_ok) ?
		modbus_pkg::CAUSE_BAD_REQ :
		tmo_hit ? modbus_pkg::CAUSE_TIMEOUT :
		rx_ferr ? modbus_pkg::CAUSE_FRAMING :
		hdr_err ? modbus_pkg::CAUSE_BAD_REPLY :
		crc_bad ? modbus_pkg::CAUSE_CRC : modbus_pkg::CAUSE_EXCEPTION;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_reg <= 1'b0;
			cause_reg <= modbus_pkg::CAUSE_NONE;
		end else if (err_set) begin
			err_reg <= 1'b1;
			cause_reg <= cause_next;
		end else if (err_clr) begin
			err_reg <= 1'b0;
			cause_reg <= modbus_pkg::CAUSE_NONE;
		end
	end

	assign port_busy_flag = busy;
	assign port_comm_error_flag = err_reg;
	assign tx_drive_en = state == modbus_pkg::ST_TX;

endmodule

`default_nettype wire

// *** design/modbus_params.svh ***
`ifndef MODBUS_PARAMS_SVH
`define MODBUS_PARAMS_SVH

// register byte offsets
`define CTRL_OFS 13'h000
`define CFG_OFS 13'h004
`define SSTART_OFS 13'h008
`define MSTART_OFS 13'h00C
`define COUNT_OFS 13'h010
`define EXCBUF_OFS 13'h014
`define STATUS_OFS 13'h018
`define MEM_BASE_BIT 12

// field positions
`define CTRL_GO_BIT 0
`define CFG_SLAVE_LSB 0
`define CFG_FC_LSB 8
`define CFG_MODE_BIT 16
`define CFG_CNTMEM_BIT 17
`define CFG_PORT_LSB 18
`define ST_BUSY_BIT 0
`define ST_ERR_BIT 1
`define ST_EXC_BIT 2
`define ST_CAUSE_LSB 8

// reset values (port field defaults to the second serial port)
`define CFG_RESET 32'h0008_0000
`define WORD_RESET 16'h0000
`define SSTART_RESET 20'h00001

// request limits
`define SERIAL_PORT_TWO 3'h2
`define MAX_SLAVE 8'hF7
`define MAX_BITS 16'h07D0
`define MAX_REGS 16'h007D

// function codes
`define FC_RD_COILS 8'h01
`define FC_RD_INPUTS 8'h02
`define FC_RD_HREGS 8'h03
`define FC_RD_IREGS 8'h04
`define FC_WR_COIL 8'h05
`define FC_WR_REG 8'h06
`define FC_RD_EXC 8'h07
`define FC_WR_COILS 8'h0F
`define FC_WR_REGS 8'h10
`define FC_EXC_BIT 8'h80

// numbering bases: 1, 1001, 3001, 4001, span 998
`define B484_COIL 20'h00001
`define B484_INP 20'h003E9
`define B484_IREG 20'h00BB9
`define B484_HREG 20'h00FA1
`define SPAN_484 20'h003E6
// five digit: 10001, 30001, 40001, span 9998
`define B5_INP 20'h02711
`define B5_IREG 20'h07531
`define B5_HREG 20'h09C41
`define SPAN_5D 20'h0270E
// six digit: 100001, 300001, 400001, span 65534
`define B6_INP 20'h186A1
`define B6_IREG 20'h493E1
`define B6_HREG 20'h61A81
`define SPAN_6D 20'h0FFFE

// crc-16, reflected polynomial
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001

// timing
`define CLK_HZ 25000000
`define BAUD_RATE 9600
`define RESP_TIMEOUT_MS 1000
`define GAP_BITS 35
`define UART_FRAME_TICKS 4'hB

`endif

// *** design/modbus_pkg.sv ***
`default_nettype none

package modbus_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_GAP = 3'h1,
		ST_TX = 3'h3,
		ST_RX = 3'h2,
		ST_EXCW = 3'h6
	} state_t;

	typedef enum logic [3:0] {
		CAUSE_NONE = 4'h0,
		CAUSE_BAD_REQ = 4'h1,
		CAUSE_TIMEOUT = 4'h2,
		CAUSE_FRAMING = 4'h3,
		CAUSE_BAD_REPLY = 4'h4,
		CAUSE_CRC = 4'h5,
		CAUSE_EXCEPTION = 4'h6
	} cause_t;

	typedef struct packed {
		logic [7:0] slave;
		logic [7:0] fc;
		logic [15:0] offset;
		logic [15:0] count;
		logic [15:0] mstart;
		logic [15:0] excbuf;
	} req_t;

	typedef struct packed {
		logic ok;
		logic [15:0] offset;
	} start_map_t;

endpackage

`default_nettype wire

// *** dv/modbus_request_checker.sv ***
`default_nettype none
`include "modbus_params.svh"
module modbus_request_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [12:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic txd,
	input wire logic tx_drive_en,
	input wire logic port_busy_flag,
	input wire logic port_comm_error_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [31:0] cfg_reg;
	wire logic wr = psel && penable && pready && pwrite;
	wire logic go = wr && paddr == `CTRL_OFS && pwdata[`CTRL_GO_BIT];
	wire logic busy = port_busy_flag;
	wire logic err = port_comm_error_flag;
	// shadow of the setup, since the block keeps its own copy hidden
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= `CFG_RESET;
		end else if (wr && paddr == `CFG_OFS) begin
			cfg_reg <= pwdata;
		end
	end
	sequence s_new;
		go && !busy;
	endsequence
	sequence s_refused;
		(err && !busy) [*4];
	endsequence
	a_bad_slave: assert property (s_new ##0 cfg_reg[7:0] > `MAX_SLAVE |=> s_refused)
		else $error("slave above 247 not refused");
	a_bad_port: assert property (s_new ##0 cfg_reg[20:18] != `SERIAL_PORT_TWO |=> s_refused)
		else $error("port other than two not refused");
	a_busy_start: assert property ($rose(busy) |-> $past(go))
		else $error("busy rose without a request");
	a_busy_hold: assert property (busy && go |=> busy)
		else $error("request while busy aborted exchange");
	a_err_clear: assert property ($fell(err) |-> $past(go))
		else $error("error flag cleared without a request");
	a_err_cause: assert property ($rose(err) |-> $past(busy) || $past(go))
		else $error("error flag set with nothing running");
	a_tx_idle: assert property (!busy |-> txd)
		else $error("line not idle outside an exchange");
	a_drv_busy: assert property (tx_drive_en |-> busy)
		else $error("driver enabled outside an exchange");
endmodule
bind modbus_rtu_master_request modbus_request_checker u_chk (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.pready(pready),
	.txd(txd),
	.tx_drive_en(tx_drive_en),
	.port_busy_flag(port_busy_flag),
	.port_comm_error_flag(port_comm_error_flag)
);
`default_nettype wire

// *** dv/modbus_slave_model.sv ***
`default_nettype none
module modbus_slave_model #(
	parameter int CPB = 8
) (
	input wire logic pclk,
	input wire logic txd,
	input wire logic exc,
	input wire logic slow,
	output logic rxd,
	output logic [63:0] last_req,
	output logic crc_bad
);
	timeunit 1ns;
	timeprecision 1ns;
	function automatic logic [15:0] crc16(input logic [63:0] v, input int n);
		logic [15:0] c;
		c = 16'hFFFF;
		for (int i = 0; i < n; i++) begin
			c ^= {8'h00, v[63-8*i -: 8]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
			end
		end
		return c;
	endfunction
	task automatic rx_byte(output logic [7:0] b);
		@(negedge txd);
		repeat (CPB / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			repeat (CPB) @(posedge pclk);
			b[i] = txd;
		end
		repeat (CPB) @(posedge pclk);
	endtask
	task automatic tx_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (CPB) @(posedge pclk);
		end
	endtask
	initial begin
		logic [7:0] b;
		logic [63:0] r;
		logic [15:0] c;
		int n;
		rxd = 1'b1;
		last_req = '0;
		crc_bad = 1'b0;
		forever begin
			for (int i = 0; i < 8; i++) begin
				rx_byte(b);
				r = {r[55:0], b};
			end
			last_req = r;
			c = crc16(r, 6);
			if (r[15:0] !== {c[7:0], c[15:8]}) crc_bad = 1'b1;
			// only station six answers, so other stations give silence
			if (r[63:56] == 8'h06) begin
				repeat ((slow ? 200 : 40) * CPB) @(posedge pclk);
				n = exc ? 3 : 5;
				r = exc ? 64'h0683_0200_0000_0000 : {24'h060302, r[47:32] ^ 16'h1234, 24'h0};
				c = crc16(r, n);
				for (int i = 0; i < n; i++) tx_byte(r[63-8*i -: 8]);
				tx_byte(c[7:0]);
				tx_byte(c[15:8]);
			end
		end
	end
endmodule
`default_nettype wire

// *** dv/modbus_rtu_master_request_tb_top.sv ***
`default_nettype none
`include "modbus_params.svh"
module modbus_rtu_master_request_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, serr, exc, slow;
	logic [12:0] paddr;
	logic [31:0] pwdata, rdat;
	wire logic [31:0] prdata;
	wire logic [63:0] req_seen;
	wire logic pready, pslverr, rxd, txd, tx_drive_en, busy, err, crc_bad;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	modbus_rtu_master_request #(.MEM_AW(10), .CLKS_PER_BIT(8), .TIMEOUT_CYCLES(2000)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
		.tx_drive_en(tx_drive_en), .port_busy_flag(busy), .port_comm_error_flag(err)
	);
	modbus_slave_model #(.CPB(8)) slave (
		.pclk(pclk), .txd(txd), .exc(exc), .slow(slow), .rxd(rxd),
		.last_req(req_seen), .crc_bad(crc_bad)
	);
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, s, e);
		end
	endtask
	// an idle edge follows each transfer, so psel never toggles twice at once
	task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no limit of its own: only the bench timeout ends a stalled access
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic req(input logic [31:0] cfg, input logic [31:0] sa, input logic b);
		apb(1'b1, `CFG_OFS, cfg);
		apb(1'b1, `SSTART_OFS, sa);
		apb(1'b1, `CTRL_OFS, 32'h1);
		apb(1'b1, `CTRL_OFS, 32'h1);
		chk({31'h0, busy}, {31'h0, b});
		while (busy === 1'b1) begin
			@(posedge pclk);
		end
		apb(1'b0, `STATUS_OFS, 32'h0);
	endtask
	initial begin
		logic [15:0] c;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 13'h0000;
		pwdata = 32'h0000_0000;
		exc = 1'b0;
		slow = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `STATUS_OFS, 32'h0);
		chk(rdat, 32'h0);
		apb(1'b0, `CFG_OFS, 32'h0);
		chk(rdat, `CFG_RESET);
		apb(1'b0, 13'h01C, 32'h0);
		chk({serr, rdat[30:0]}, 32'h8000_0000);
		apb(1'b1, `MSTART_OFS, 32'h10);
		apb(1'b1, `COUNT_OFS, 32'h1);
		apb(1'b1, `EXCBUF_OFS, 32'h20);
		req(32'h0008_03F8, 32'hFA1, 1'b0);
		chk(rdat, 32'h102);
		req(32'h000C_0306, 32'hFA1, 1'b0);
		chk(rdat, 32'h102);
		req(32'h0008_0306, 32'hFA1, 1'b1);
		chk(rdat, 32'h0);
		chk(req_seen[63:32], 32'h0603_0000);
		chk({16'h0, req_seen[31:16]}, 32'h1);
		apb(1'b0, 13'h1040, 32'h0);
		chk(rdat, 32'h1234);
		slow <= 1'b1;
		req(32'h0009_0306, 32'h61A83, 1'b1);
		chk(req_seen[63:32], 32'h0603_0002);
		apb(1'b0, 13'h1040, 32'h0);
		chk(rdat, 32'h1236);
		slow <= 1'b0;
		req(32'h0008_0606, 32'hFA1, 1'b1);
		chk(rdat & 32'hF03, 32'h402);
		chk(req_seen[63:32], 32'h0606_0000);
		chk(req_seen[47:16], 32'h0000_1236);
		// the slave answers a write like a read; let the rest of it drain
		repeat (500) @(posedge pclk);
		exc <= 1'b1;
		req(32'h0008_0306, 32'hFA1, 1'b1);
		chk(rdat & 32'hF03, 32'h602);
		c = slave.crc16(64'h0683_0200_0000_0000, 3);
		apb(1'b0, 13'h1080, 32'h0);
		chk(rdat, 32'h8306);
		apb(1'b0, 13'h1084, 32'h0);
		chk(rdat, {16'h0, c[7:0], 8'h02});
		apb(1'b0, 13'h1088, 32'h0);
		chk(rdat, {24'h0, c[15:8]});
		exc <= 1'b0;
		req(32'h0008_0307, 32'hFA1, 1'b1);
		chk(rdat & 32'hF03, 32'h202);
		chk({31'h0, crc_bad}, 32'h0);
		test_done();
	end
endmodule
`default_nettype wire
